// ==== core/evio_pkg.sv ====
// Package of constants and types for the auxiliary event input and pulse output block.
package evio_pkg;
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned SECOND_NS         = 1_000_000_000;
  localparam int unsigned SEC_CYCLES        = (SECOND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_MAX_PER_SEC = 20;
  localparam int unsigned PULSE_GAP_NS      = SECOND_NS / PULSE_MAX_PER_SEC;
  localparam int unsigned PULSE_GAP_CYCLES  =
    (PULSE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_ON_NS       = PULSE_GAP_NS / 2;
  localparam int unsigned PULSE_ON_CYCLES   = PULSE_ON_NS / CLK_PERIOD_NS;
  localparam int unsigned PREFAULT_DEPTH    = 32;
  localparam int unsigned PREFAULT_AW       = 5;
  localparam int unsigned NUM_EVENTS        = 4;
  localparam int unsigned IRQ_W             = 4;

  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_LOGTIME    = 8'h04;
  localparam logic [7:0] ADDR_RELAY      = 8'h08;
  localparam logic [7:0] ADDR_PULSE      = 8'h0c;
  localparam logic [7:0] ADDR_SCALE      = 8'h10;
  localparam logic [7:0] ADDR_STATE      = 8'h14;
  localparam logic [7:0] ADDR_ERASE      = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h20;
  localparam logic [7:0] ADDR_PRE_INDEX  = 8'h24;
  localparam logic [7:0] ADDR_PRE_DATA   = 8'h28;

  localparam int unsigned CTRL_EN_LSB    = 0;
  localparam int unsigned CTRL_POL_LSB   = 4;
  localparam int unsigned CTRL_SEL_LSB   = 8;
  localparam int unsigned CTRL_IDLE_LSB  = 12;
  localparam int unsigned LOG_MAX_LSB    = 0;
  localparam int unsigned LOG_POST_LSB   = 16;
  localparam int unsigned RELAY2_LSB     = 0;
  localparam int unsigned RELAY3_LSB     = 8;
  localparam int unsigned PULSE_CHAN_LSB = 0;
  localparam int unsigned PULSE_KIND_LSB = 4;
  localparam int unsigned ST_SEL_BIT     = 0;
  localparam int unsigned ST_ALL_LSB     = 4;
  localparam int unsigned ST_LOG_BIT     = 8;
  localparam int unsigned ST_OWED_LSB    = 16;
  localparam int unsigned ERASE_ARM      = 0;
  localparam int unsigned ERASE_YES      = 1;
  localparam int unsigned IRQ_EVENT      = 0;
  localparam int unsigned IRQ_DONE       = 1;
  localparam int unsigned IRQ_ERASED     = 2;
  localparam int unsigned IRQ_OVER       = 3;

  localparam logic [31:0] CTRL_MASK     = 32'h0000_33ff;
  localparam logic [31:0] RELAY_MASK    = 32'h0000_1f1f;
  localparam logic [31:0] PULSE_MASK    = 32'h0000_0033;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_00f0;
  localparam logic [31:0] LOGTIME_RESET = 32'h000a_000a;
  localparam logic [31:0] RELAY_RESET   = 32'h0000_0000;
  localparam logic [31:0] PULSE_RESET   = 32'h0000_0003;
  localparam logic [31:0] SCALE_RESET   = 32'h0000_0001;

  typedef enum logic [1:0] {CHAN_A, CHAN_B, CHAN_C, CHAN_TOTAL} evio_chan_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  kind;
    logic [15:0] phase_a;
    logic [15:0] phase_b;
    logic [15:0] phase_c;
  } evio_qty_t;
endpackage

// ==== core/evio_event_in.sv ====
// One event input: two-stage synchroniser followed by polarity evaluation.
`timescale 1ns/1ns
module evio_event_in (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raw,
  input  wire logic active_level,
  output logic      active
);
  logic sync1;
  logic sync2;
  logic next_sync1;
  logic next_sync2;

  always_comb begin
    next_sync1 = raw;
    next_sync2 = sync1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  assign active = (sync2 == active_level);
endmodule // evio_event_in

// ==== core/evio_aux_io.sv ====
// Auxiliary event inputs, relays, energy pulse output and APB register file.
`timescale 1ns/1ns
module evio_aux_io
  import evio_pkg::*;
#(
  parameter int unsigned SEC_CYC = SEC_CYCLES,
  parameter int unsigned GAP_CYC = PULSE_GAP_CYCLES,
  parameter int unsigned ON_CYC  = PULSE_ON_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [3:0]  ev_in,
  input  wire logic [31:0] meas_trig,
  input  wire evio_qty_t   qty,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  output logic [1:0]       relay_out,
  output logic             kyz_out,
  output logic             sec_rec_strobe,
  output logic             wave_log_en,
  output logic             erase_all,
  output logic             irq
);
  typedef enum logic [1:0] {LOG_IDLE, LOG_ACTIVE, LOG_LIMIT, LOG_POST} evio_log_t;

  logic [31:0]            ctrl, next_ctrl, logtime, next_logtime;
  logic [31:0]            relay_cfg, next_relay_cfg, pulse_cfg, next_pulse_cfg;
  logic [31:0]            pulse_scale_factor, next_scale;
  logic [IRQ_W-1:0]       irq_status, next_irq_status, irq_mask, next_irq_mask, irq_set;
  logic [PREFAULT_AW-1:0] pre_index, next_pre_index;
  logic                   erase_arm, next_erase_arm, next_erase_all;
  logic [31:0]            next_rdata;
  logic                   wr_en, rd_setup, addr_hit;
  logic [3:0]             ev_act, ev_enable, ev_pol;
  logic [1:0]             event_input_select, relay_idle;
  logic                   ev_sel_state, trig;
  logic [15:0]            max_active_log_seconds, post_fault_seconds;
  logic [4:0]             relay2_sel, relay3_sel;
  logic [1:0]             next_relay;
  evio_log_t              log_state, next_log_state;
  logic [31:0]            tick_cnt, next_tick_cnt;
  logic [15:0]            sec_cnt, next_sec_cnt;
  logic                   tick, next_rec, log_start, log_done;
  logic [15:0]            ring [PREFAULT_DEPTH];
  logic [PREFAULT_AW-1:0] wr_ptr, next_wr_ptr, pre_base, next_pre_base;
  logic [PREFAULT_AW-1:0] pre_addr;
  logic [17:0]            lane;
  logic [32:0]            acc_sum;
  logic [31:0]            acc, next_acc, gap_cnt, next_gap_cnt;
  logic [15:0]            owed, next_owed;
  logic                   next_kyz, pulse_start, earned;

  assign ev_enable              = ctrl[CTRL_EN_LSB +: 4];
  assign ev_pol                 = ctrl[CTRL_POL_LSB +: 4];
  assign event_input_select     = ctrl[CTRL_SEL_LSB +: 2];
  assign relay_idle             = ctrl[CTRL_IDLE_LSB +: 2];
  assign max_active_log_seconds = logtime[LOG_MAX_LSB +: 16];
  assign post_fault_seconds     = logtime[LOG_POST_LSB +: 16];
  assign relay2_sel             = relay_cfg[RELAY2_LSB +: 5];
  assign relay3_sel             = relay_cfg[RELAY3_LSB +: 5];

  // APB slave: no wait states, unmapped addresses answer with an error.
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pslverr  = psel & penable & ~addr_hit;

  always_comb begin
    case (paddr)
      ADDR_CTRL, ADDR_LOGTIME, ADDR_RELAY, ADDR_PULSE, ADDR_SCALE, ADDR_STATE,
      ADDR_ERASE, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_PRE_INDEX,
      ADDR_PRE_DATA: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_ev
    evio_event_in u_ev (
      .pclk         (pclk),
      .presetn      (presetn),
      .raw          (ev_in[i]),
      .active_level (ev_pol[i]),
      .active       (ev_act[i])
    );
  end

  assign ev_sel_state = ev_act[event_input_select];
  assign trig         = |(ev_act & ev_enable);

  assign irq_set[IRQ_EVENT]  = log_start;
  assign irq_set[IRQ_DONE]   = log_done;
  assign irq_set[IRQ_ERASED] = erase_all;
  assign irq_set[IRQ_OVER]   = owed > 16'h0001;

  always_comb begin
    next_ctrl       = ctrl;
    next_logtime    = logtime;
    next_relay_cfg  = relay_cfg;
    next_pulse_cfg  = pulse_cfg;
    next_scale      = pulse_scale_factor;
    next_irq_mask   = irq_mask;
    next_pre_index  = pre_index;
    next_erase_arm  = erase_arm;
    next_erase_all  = 1'b0;
    next_irq_status = irq_status;
    if (wr_en) begin
      case (paddr)
        ADDR_CTRL:       next_ctrl = pwdata & CTRL_MASK;
        ADDR_LOGTIME:    next_logtime = pwdata;
        ADDR_RELAY:      next_relay_cfg = pwdata & RELAY_MASK;
        ADDR_PULSE:      next_pulse_cfg = pwdata & PULSE_MASK;
        ADDR_SCALE:      next_scale = pwdata;
        ADDR_IRQ_STATUS: next_irq_status = irq_status & ~pwdata[IRQ_W-1:0];
        ADDR_IRQ_MASK:   next_irq_mask = pwdata[IRQ_W-1:0];
        ADDR_PRE_INDEX:  next_pre_index = pwdata[PREFAULT_AW-1:0];
        ADDR_ERASE: begin
          next_erase_all = pwdata[ERASE_YES] & erase_arm;
          next_erase_arm = pwdata[ERASE_ARM] & ~pwdata[ERASE_YES];
        end
        default: begin
        end
      endcase
    end
    next_irq_status = next_irq_status | irq_set;
  end

  assign pre_addr = pre_base + pre_index;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      ADDR_CTRL:       next_rdata = ctrl;
      ADDR_LOGTIME:    next_rdata = logtime;
      ADDR_RELAY:      next_rdata = relay_cfg;
      ADDR_PULSE:      next_rdata = pulse_cfg;
      ADDR_SCALE:      next_rdata = pulse_scale_factor;
      ADDR_STATE: begin
        next_rdata[ST_SEL_BIT]        = ev_sel_state;
        next_rdata[ST_ALL_LSB +: 4]   = ev_act;
        next_rdata[ST_LOG_BIT]        = wave_log_en;
        next_rdata[ST_OWED_LSB +: 16] = owed;
      end
      ADDR_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
      ADDR_IRQ_MASK:   next_rdata[IRQ_W-1:0] = irq_mask;
      ADDR_PRE_INDEX:  next_rdata[PREFAULT_AW-1:0] = pre_index;
      ADDR_PRE_DATA:   next_rdata[15:0] = ring[pre_addr];
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl               <= CTRL_RESET;
      logtime            <= LOGTIME_RESET;
      relay_cfg          <= RELAY_RESET;
      pulse_cfg          <= PULSE_RESET;
      pulse_scale_factor <= SCALE_RESET;
      irq_status         <= '0;
      irq_mask           <= '0;
      pre_index          <= '0;
      erase_arm          <= 1'b0;
      erase_all          <= 1'b0;
      prdata             <= 32'h0000_0000;
    end else begin
      ctrl               <= next_ctrl;
      logtime            <= next_logtime;
      relay_cfg          <= next_relay_cfg;
      pulse_cfg          <= next_pulse_cfg;
      pulse_scale_factor <= next_scale;
      irq_status         <= next_irq_status;
      irq_mask           <= next_irq_mask;
      pre_index          <= next_pre_index;
      erase_arm          <= next_erase_arm;
      erase_all          <= next_erase_all;
      if (rd_setup) begin
        prdata <= next_rdata;
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Logging window: whole seconds while active, then the post-fault tail.
  assign tick = (tick_cnt == SEC_CYC - 1);

  always_comb begin
    next_log_state = log_state;
    next_sec_cnt   = sec_cnt;
    next_tick_cnt  = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    next_rec       = 1'b0;
    log_start      = 1'b0;
    log_done       = 1'b0;
    case (log_state)
      LOG_IDLE: begin
        next_tick_cnt = 32'h0000_0000;
        if (trig) begin
          next_log_state = LOG_ACTIVE;
          next_sec_cnt   = 16'h0000;
          log_start      = 1'b1;
        end
      end
      LOG_ACTIVE: begin
        if (!trig) begin
          next_log_state = LOG_POST;
          next_sec_cnt   = 16'h0000;
          next_tick_cnt  = 32'h0000_0000;
        end else if (tick) begin
          next_rec     = 1'b1;
          next_sec_cnt = sec_cnt + 16'h0001;
          if (next_sec_cnt >= max_active_log_seconds) begin
            next_log_state = LOG_LIMIT;
          end
        end
      end
      LOG_LIMIT: begin
        if (!trig) begin
          next_log_state = LOG_POST;
          next_sec_cnt   = 16'h0000;
          next_tick_cnt  = 32'h0000_0000;
        end
      end
      LOG_POST: begin
        if (trig) begin
          next_log_state = LOG_ACTIVE;
          next_sec_cnt   = 16'h0000;
          next_tick_cnt  = 32'h0000_0000;
        end else if (post_fault_seconds == 16'h0000) begin
          next_log_state = LOG_IDLE;
          log_done       = 1'b1;
        end else if (tick) begin
          next_rec     = 1'b1;
          next_sec_cnt = sec_cnt + 16'h0001;
          if (next_sec_cnt >= post_fault_seconds) begin
            next_log_state = LOG_IDLE;
            log_done       = 1'b1;
          end
        end
      end
      default: next_log_state = LOG_IDLE;
    endcase
  end

  assign wave_log_en = (log_state == LOG_ACTIVE) || (log_state == LOG_POST);

  // Prefault ring keeps filling while idle and freezes once a record starts.
  always_comb begin
    next_wr_ptr   = wr_ptr;
    next_pre_base = pre_base;
    if (sample_valid && log_state == LOG_IDLE) begin
      next_wr_ptr = wr_ptr + 5'h01;
    end
    if (log_start) begin
      next_pre_base = next_wr_ptr;
    end
  end

  always_ff @(posedge pclk) begin
    if (sample_valid && log_state == LOG_IDLE) begin
      ring[wr_ptr] <= sample_data;
    end
  end

  // Relays follow the chosen trigger and fall back to their idle level.
  assign next_relay = relay_idle ^ {meas_trig[relay3_sel], meas_trig[relay2_sel]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_state      <= LOG_IDLE;
      sec_cnt        <= 16'h0000;
      tick_cnt       <= 32'h0000_0000;
      sec_rec_strobe <= 1'b0;
      wr_ptr         <= '0;
      pre_base       <= '0;
      relay_out      <= 2'b00;
    end else begin
      log_state      <= next_log_state;
      sec_cnt        <= next_sec_cnt;
      tick_cnt       <= next_tick_cnt;
      sec_rec_strobe <= next_rec;
      wr_ptr         <= next_wr_ptr;
      pre_base       <= next_pre_base;
      relay_out      <= next_relay;
    end
  end

  // Energy pulse path: accumulate, owe pulses, pay them out at the rate limit.
  always_comb begin
    case (evio_chan_t'(pulse_cfg[PULSE_CHAN_LSB +: 2]))
      CHAN_A:  lane = {2'b00, qty.phase_a};
      CHAN_B:  lane = {2'b00, qty.phase_b};
      CHAN_C:  lane = {2'b00, qty.phase_c};
      default: lane = 18'({2'b00, qty.phase_a}) + 18'(qty.phase_b) + 18'(qty.phase_c);
    endcase
  end

  assign acc_sum = {1'b0, acc} +
    ((qty.valid && qty.kind == pulse_cfg[PULSE_KIND_LSB +: 2]) ? 33'(lane) : 33'h0);
  assign earned      = (pulse_scale_factor != 32'h0) && (acc_sum >= 33'(pulse_scale_factor));
  assign pulse_start = (gap_cnt == 32'h0) && (owed != 16'h0000);

  always_comb begin
    next_acc     = earned ? 32'(acc_sum - 33'(pulse_scale_factor)) : acc_sum[31:0];
    next_owed    = owed;
    next_gap_cnt = (gap_cnt != 32'h0) ? gap_cnt - 32'h1 : gap_cnt;
    if (earned && owed != 16'hffff) begin
      next_owed = next_owed + 16'h0001;
    end
    if (pulse_start) begin
      next_owed    = next_owed - 16'h0001;
      next_gap_cnt = GAP_CYC - 1;
    end
    next_kyz = pulse_start | (kyz_out & (gap_cnt > GAP_CYC - ON_CYC));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc     <= 32'h0000_0000;
      owed    <= 16'h0000;
      gap_cnt <= 32'h0000_0000;
      kyz_out <= 1'b0;
    end else begin
      acc     <= next_acc;
      owed    <= next_owed;
      gap_cnt <= next_gap_cnt;
      kyz_out <= next_kyz;
    end
  end

  // Checks.
  logic [1:0]  up_cnt;
  logic [31:0] since_pulse;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt      <= 2'b00;
      since_pulse <= 32'hffff_ffff;
    end else begin
      up_cnt      <= (up_cnt == 2'b11) ? up_cnt : up_cnt + 2'b01;
      since_pulse <= pulse_start ? 32'h1 :
        (since_pulse == 32'hffff_ffff ? since_pulse : since_pulse + 32'h1);
    end
  end

  property p_sync_pol;
    @(posedge pclk) disable iff (!presetn)
      up_cnt == 2'b11 |-> ev_act == ~($past(ev_in, 2) ^ ev_pol);
  endproperty
  a_sync_pol: assert property (p_sync_pol) else $error("event input mismatch");

  property p_state_ind;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && paddr == ADDR_STATE |=> prdata[ST_SEL_BIT] == $past(ev_sel_state);
  endproperty
  a_state_ind: assert property (p_state_ind) else $error("state bit wrong");

  property p_rate;
    @(posedge pclk) disable iff (!presetn)
      pulse_start |-> since_pulse >= GAP_CYC;
  endproperty
  a_rate: assert property (p_rate) else $error("pulse rate exceeded");

  property p_owed_pay;
    @(posedge pclk) disable iff (!presetn)
      pulse_start && !earned |=> owed == $past(owed) - 16'h0001 ##0 kyz_out;
  endproperty
  a_owed_pay: assert property (p_owed_pay) else $error("owed count not paid");

  property p_max_log;
    @(posedge pclk) disable iff (!presetn)
      log_state == LOG_ACTIVE |-> sec_cnt < max_active_log_seconds || sec_cnt == 16'h0;
  endproperty
  a_max_log: assert property (p_max_log) else $error("active log too long");

  property p_post_end;
    @(posedge pclk) disable iff (!presetn)
      log_state == LOG_ACTIVE && !trig |=> log_state == LOG_POST && wave_log_en;
  endproperty
  a_post_end: assert property (p_post_end) else $error("post-fault not entered");

  property p_relay_set;
    @(posedge pclk) disable iff (!presetn)
      $rose(meas_trig[relay2_sel]) && $stable(relay2_sel) && $stable(relay_idle[0])
      |=> relay_out[0] == ~relay_idle[0];
  endproperty
  a_relay_set: assert property (p_relay_set) else $error("relay did not switch");

  property p_relay_back;
    @(posedge pclk) disable iff (!presetn)
      $fell(meas_trig[relay3_sel]) && $stable(relay3_sel) && $stable(relay_idle[1])
      |=> relay_out[1] == relay_idle[1];
  endproperty
  a_relay_back: assert property (p_relay_back) else $error("relay did not revert");

  property p_erase;
    @(posedge pclk) disable iff (!presetn)
      erase_all |-> $past(erase_arm) && $past(wr_en) && $past(pwdata[ERASE_YES]);
  endproperty
  a_erase: assert property (p_erase) else $error("erase without confirm");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      log_state == LOG_IDLE && trig |=> log_state == LOG_ACTIVE ##0 irq_status[IRQ_EVENT];
  endproperty
  a_start: assert property (p_start) else $error("event did not start log");
endmodule // evio_aux_io

// ==== bench/evio_partner.sv ====
// Far-side model: four event signal sources and a meter that counts energy pulses.
`timescale 1ns/1ns
module evio_partner (
  input  wire logic       pclk,
  input  wire logic [3:0] ev_lvl,
  input  wire logic       kyz_out,
  output logic      [3:0] ev_in,
  output int              pulses,
  output int              min_gap
);
  int   gap;
  logic kyz_q;
  initial begin
    ev_in = 4'hf;
    kyz_q = 1'b0;
    gap = 1000;
    pulses = 0;
    min_gap = 1000;
  end
  // Sources change their levels just after a clock edge.
  always @(posedge pclk) begin
    ev_in <= ev_lvl;
    kyz_q <= kyz_out;
    gap <= gap + 1;
    if (kyz_out === 1'b1 && kyz_q === 1'b0) begin
      pulses <= pulses + 1;
      gap <= 1;
      if (gap < min_gap) begin
        min_gap <= gap;
      end
    end
  end
endmodule // evio_partner

// ==== bench/testbench.sv ====
// Self-checking testbench for the auxiliary event input and pulse output block.
`timescale 1ns/1ns
module testbench;
  import evio_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, meas_trig = '0, prdata;
  logic [3:0]  ev_lvl = 4'hf, ev_in;
  evio_qty_t   qty = '0;
  logic        pready, pslverr, kyz_out, sec_rec_strobe, wave_log_en, erase_all, irq;
  logic        sample_valid = 0;
  logic [15:0] sample_data = '0;
  logic [1:0]  relay_out;
  logic [32:0] qe[$], qm[$];
  int          err_count = 0, cmp_count = 0, nstr = 0, ner = 0, pulses, min_gap;
  int          seed = 32'h9630;
  always #4 pclk = ~pclk;
  evio_aux_io #(.SEC_CYC(20), .GAP_CYC(10), .ON_CYC(5)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ev_in(ev_in),
    .meas_trig(meas_trig), .qty(qty), .sample_valid(sample_valid), .sample_data(sample_data),
    .relay_out(relay_out), .kyz_out(kyz_out), .sec_rec_strobe(sec_rec_strobe),
    .wave_log_en(wave_log_en), .erase_all(erase_all), .irq(irq));
  evio_partner far (.pclk(pclk), .ev_lvl(ev_lvl), .kyz_out(kyz_out), .ev_in(ev_in),
    .pulses(pulses), .min_gap(min_gap));
  task chk(input string n, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    qe.push_back(e & m);
    qm.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  task sendq(input logic [1:0] k);
    @(posedge pclk);
    qty.valid <= 1'b1;
    qty.kind <= k;
    qty.phase_a <= 16'h6;
    qty.phase_b <= 16'($random(seed));
    @(posedge pclk);
    qty.valid <= 1'b0;
  endtask
  // Read answers are matched against the oldest noted expectation.
  always @(posedge pclk) begin
    nstr <= nstr + (sec_rec_strobe === 1'b1);
    ner <= ner + (erase_all === 1'b1);
    if (psel && penable && pready === 1'b1 && !pwrite && qe.size() > 0) begin
      chk("read", qe.pop_front(), {pslverr, prdata} & qm.pop_front());
    end
  end
  initial begin
    repeat (6000) @(posedge pclk);
    err_count++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CTRL, {1'b0, CTRL_RESET}, '1);
    rd(ADDR_LOGTIME, {1'b0, LOGTIME_RESET}, '1);
    rd(ADDR_RELAY, {1'b0, RELAY_RESET}, '1);
    rd(ADDR_PULSE, {1'b0, PULSE_RESET}, '1);
    rd(ADDR_SCALE, {1'b0, SCALE_RESET}, '1);
    rd(8'h40, 33'h1_0000_0000, '1);
    $display("register test done");
    bus(1'b1, ADDR_LOGTIME, 32'h0001_0002);
    bus(1'b1, ADDR_IRQ_MASK, 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h0000_20e1);
    rd(ADDR_STATE, 33'h0, 33'h101);
    for (int k = 0; k < 40; k++) begin
      sample_valid <= 1'b1;
      sample_data <= 16'h0100 + 16'(k);
      @(posedge pclk);
    end
    sample_valid <= 1'b0;
    ev_lvl <= 4'he;
    repeat (6) @(posedge pclk);
    chk("logging", 33'h1, wave_log_en);
    chk("irq", 33'h1, irq);
    rd(ADDR_STATE, 33'h111, 33'h111);
    repeat (50) @(posedge pclk);
    chk("records", 33'h2, nstr);
    chk("limit", 33'h0, wave_log_en);
    ev_lvl <= 4'hf;
    repeat (60) @(posedge pclk);
    chk("records", 33'h3, nstr);
    rd(ADDR_IRQ_STATUS, 33'h3, 33'h3);
    bus(1'b1, ADDR_IRQ_STATUS, 32'hf);
    @(posedge pclk);
    chk("irq", 33'h0, irq);
    rd(ADDR_PRE_DATA, 33'h108, '1);
    bus(1'b1, ADDR_PRE_INDEX, 32'h1f);
    rd(ADDR_PRE_DATA, 33'h127, '1);
    $display("event test done");
    bus(1'b1, ADDR_RELAY, 32'h0000_1f05);
    repeat (4) begin
      meas_trig <= $random(seed);
      repeat (2) @(posedge pclk);
      chk("relay", {31'h0, ~meas_trig[31], meas_trig[5]}, relay_out);
    end
    $display("relay test done");
    bus(1'b1, ADDR_PULSE, 32'h0);
    bus(1'b1, ADDR_SCALE, 32'h2);
    sendq(2'h1);
    sendq(2'h0);
    repeat (60) @(posedge pclk);
    chk("pulses", 33'h3, pulses);
    chk("gap", 33'h1, min_gap >= 10);
    rd(ADDR_IRQ_STATUS, 33'h8, 33'h8);
    rd(ADDR_STATE, 33'h0, 33'hffff_0000);
    $display("pulse test done");
    bus(1'b1, ADDR_ERASE, 32'h2);
    bus(1'b1, ADDR_ERASE, 32'h1);
    bus(1'b1, ADDR_ERASE, 32'h2);
    repeat (2) @(posedge pclk);
    chk("erase", 33'h1, ner);
    rd(ADDR_IRQ_STATUS, 33'h4, 33'h4);
    $display("erase test done");
    complete_run;
  end
endmodule // testbench
